/* File: hdl/tw_cfg.svh */
/*
  Register offsets, field positions, reset values and prescaler masks of the
  8-bit timer waveform block. Assumes inclusion by bare name from the package
  and the top module.
*/
`ifndef TW_CFG_SVH
`define TW_CFG_SVH

`define TW_ADDR_W        8
`define TW_OFF_CTRL_A    8'hB0
`define TW_OFF_CTRL_B    8'hB4
`define TW_OFF_COUNT     8'hB8
`define TW_OFF_CMP_A     8'hBC
`define TW_OFF_CMP_B     8'hC0
`define TW_OFF_IRQ_STAT  8'hC4
`define TW_OFF_IRQ_MASK  8'hC8
`define TW_OFF_PORT      8'hCC

`define TW_CTRL_A_RST    8'h00
`define TW_CTRL_A_RMASK  8'hF3
`define TW_CTRL_B_RMASK  8'h0F
`define TW_BIT_FORCE_A   7
`define TW_BIT_FORCE_B   6
`define TW_BIT_WAVE_HI   3

`define TW_STAT_OVF      0
`define TW_STAT_MATCH_A  1
`define TW_STAT_MATCH_B  2

`define TW_TOP_MAX       8'hFF
`define TW_BOTTOM        8'h00

`define TW_DIV_1         10'h000
`define TW_DIV_8         10'h007
`define TW_DIV_32        10'h01F
`define TW_DIV_64        10'h03F
`define TW_DIV_128       10'h07F
`define TW_DIV_256       10'h0FF
`define TW_DIV_1024      10'h3FF

`endif

/* File: hdl/tw_pkg.sv */
/*
  Types of the 8-bit timer waveform block: APB carriers, pin carrier,
  waveform kinds and the block's whole state. Assumes tw_cfg.svh.
*/
`include "tw_cfg.svh"

package tw_pkg;

    typedef enum logic [3:0] {
        TW_NONPWM = 4'b0001,
        TW_FAST   = 4'b0010,
        TW_PHASE  = 4'b0100,
        TW_RSVD   = 4'b1000
    } tw_wave_t;

    typedef struct packed {
        logic                   psel;
        logic                   penable;
        logic                   pwrite;
        logic [`TW_ADDR_W-1:0]  paddr;
        logic [31:0]            pwdata;
    } tw_apb_req_t;

    typedef struct packed {
        logic                   pready;
        logic                   pslverr;
        logic [31:0]            prdata;
    } tw_apb_rsp_t;

    typedef struct packed {
        logic                   out;
        logic                   oe_n;
    } tw_pin_t;

    typedef struct packed {
        logic [7:0]             ctrl_a;
        logic [3:0]             ctrl_b;
        logic [7:0]             cnt;
        logic [7:0]             cmp_a;
        logic [7:0]             cmp_b;
        logic [7:0]             act_a;
        logic [7:0]             act_b;
        logic                   count_up;
        logic                   block;
        logic [9:0]             pre;
        logic [2:0]             stat;
        logic [2:0]             mask;
        logic [3:0]             port;
        logic                   oc_a;
        logic                   oc_b;
        tw_pin_t                pin_a;
        tw_pin_t                pin_b;
        logic                   irq;
        tw_apb_rsp_t            rsp;
    } tw_state_t;

endpackage

/* File: hdl/tw_top.sv */
/*
  8-bit timer/counter with waveform generation and two compare outputs,
  reached as an APB slave. Assumes one 10 MHz clock pclk, an active-low
  asynchronous reset, and a pad that resolves the pins from out and oe_n.
*/
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`include "tw_cfg.svh"

module tw_top
    import tw_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire tw_pkg::tw_apb_req_t apb_req,
    output tw_pkg::tw_apb_rsp_t      apb_rsp,
    output tw_pkg::tw_pin_t          pin_a,
    output tw_pkg::tw_pin_t          pin_b,
    output logic                     irq
);
    import tw_pkg::*;

    tw_state_t st;
    tw_state_t next_st;

    function automatic logic [9:0] div_mask(input logic [2:0] sel);
        case (sel)
            3'd1:    div_mask = `TW_DIV_1;
            3'd2:    div_mask = `TW_DIV_8;
            3'd3:    div_mask = `TW_DIV_32;
            3'd4:    div_mask = `TW_DIV_64;
            3'd5:    div_mask = `TW_DIV_128;
            3'd6:    div_mask = `TW_DIV_256;
            default: div_mask = `TW_DIV_1024;
        endcase
    endfunction

    function automatic tw_wave_t wave_kind(input logic [2:0] mode);
        case (mode)
            3'd0, 3'd2: wave_kind = TW_NONPWM;
            3'd1, 3'd5: wave_kind = TW_PHASE;
            3'd3, 3'd7: wave_kind = TW_FAST;
            default:    wave_kind = TW_RSVD;
        endcase
    endfunction

    // New level of one compare output for this cycle's events
    function automatic logic oc_step(
        input logic [1:0] com,
        input tw_wave_t   kind,
        input logic       match,
        input logic       force_hit,
        input logic       wrap,
        input logic       peak,
        input logic       up,
        input logic       cmp_top,
        input logic       toggle_ok,
        input logic       oc
    );
        logic r;
        r = oc;
        case (kind)
            TW_NONPWM: begin
                if (match || force_hit) begin
                    case (com)
                        2'b01:   r = ~oc;
                        2'b10:   r = 1'b0;
                        2'b11:   r = 1'b1;
                        default: r = oc;
                    endcase
                end
            end
            TW_FAST: begin
                if (com[1]) begin
                    if (wrap) begin
                        r = ~com[0];
                    end else if (match && !cmp_top) begin
                        r = com[0];
                    end
                end else if (com[0] && toggle_ok && match) begin
                    r = ~oc;
                end
            end
            TW_PHASE: begin
                if (com[1]) begin
                    if (cmp_top) begin
                        if (peak) begin
                            r = ~com[0];
                        end
                    end else if (match) begin
                        r = up ? com[0] : ~com[0];
                    end
                end else if (com[0] && toggle_ok && match) begin
                    r = ~oc;
                end
            end
            default: r = oc;
        endcase
        oc_step = r;
    endfunction

    function automatic logic [7:0] reg_read(input tw_state_t s, input logic [`TW_ADDR_W-1:0] a);
        case (a)
            `TW_OFF_CTRL_A:   reg_read = s.ctrl_a & `TW_CTRL_A_RMASK;
            `TW_OFF_CTRL_B:   reg_read = {4'h0, s.ctrl_b} & `TW_CTRL_B_RMASK;
            `TW_OFF_COUNT:    reg_read = s.cnt;
            `TW_OFF_CMP_A:    reg_read = s.cmp_a;
            `TW_OFF_CMP_B:    reg_read = s.cmp_b;
            `TW_OFF_IRQ_STAT: reg_read = {5'h00, s.stat};
            `TW_OFF_IRQ_MASK: reg_read = {5'h00, s.mask};
            `TW_OFF_PORT:     reg_read = {4'h0, s.port};
            default:          reg_read = 8'h00;
        endcase
    endfunction

    function automatic logic mapped(input logic [`TW_ADDR_W-1:0] a);
        case (a)
            `TW_OFF_CTRL_A, `TW_OFF_CTRL_B, `TW_OFF_COUNT, `TW_OFF_CMP_A,
            `TW_OFF_CMP_B, `TW_OFF_IRQ_STAT, `TW_OFF_IRQ_MASK, `TW_OFF_PORT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    logic [2:0]  mode;
    tw_wave_t    kind;
    logic [7:0]  top;
    logic        tick;
    logic        at_top;
    logic        wrap;
    logic        peak;
    logic        ovf;
    logic        match_a;
    logic        match_b;
    logic        setup;
    logic        access;
    logic        wr;
    logic        force_a;
    logic        force_b;
    logic [2:0]  stat_set;
    logic [7:0]  wbyte;
    tw_wave_t    next_kind;
    logic        link_a;

    always_comb begin
        next_st = st;
        mode    = {st.ctrl_b[`TW_BIT_WAVE_HI], st.ctrl_a[1:0]};
        kind    = wave_kind(mode);
        top     = (mode[2] || mode == 3'd2) ? st.act_a : `TW_TOP_MAX;
        wbyte   = apb_req.pwdata[7:0];

        // Prescaler runs only while a source is selected
        next_st.pre = (st.ctrl_b[2:0] == 3'd0) ? 10'h000 : 10'(st.pre + 10'd1);
        tick = (st.ctrl_b[2:0] != 3'd0) &&
               ((st.pre & div_mask(st.ctrl_b[2:0])) == div_mask(st.ctrl_b[2:0]));

        match_a = tick && !st.block && (st.cnt == st.act_a) && (kind != TW_RSVD);
        match_b = tick && !st.block && (st.cnt == st.act_b) && (kind != TW_RSVD);
        at_top  = tick && (st.cnt == top);
        wrap    = 1'b0;
        peak    = 1'b0;
        ovf     = 1'b0;
        if (tick) begin
            next_st.block = 1'b0;
        end

        case (kind)
            TW_NONPWM: begin
                if (tick) begin
                    next_st.cnt = at_top ? `TW_BOTTOM : 8'(st.cnt + 8'd1);
                    ovf = (st.cnt == `TW_TOP_MAX);
                end
                next_st.count_up = 1'b1;
            end
            TW_FAST: begin
                if (tick) begin
                    next_st.cnt = at_top ? `TW_BOTTOM : 8'(st.cnt + 8'd1);
                    wrap = at_top;
                    ovf  = mode[2] ? at_top : (st.cnt == `TW_TOP_MAX);
                    if (at_top) begin
                        next_st.act_a = st.cmp_a;
                        next_st.act_b = st.cmp_b;
                    end
                end
                next_st.count_up = 1'b1;
            end
            TW_PHASE: begin
                if (tick) begin
                    if (st.count_up) begin
                        if (at_top) begin
                            peak = 1'b1;
                            next_st.count_up = 1'b0;
                            next_st.cnt = 8'(st.cnt - 8'd1);
                            next_st.act_a = st.cmp_a;
                            next_st.act_b = st.cmp_b;
                        end else begin
                            next_st.cnt = 8'(st.cnt + 8'd1);
                        end
                    end else if (st.cnt == `TW_BOTTOM) begin
                        ovf = 1'b1;
                        next_st.count_up = 1'b1;
                        next_st.cnt = 8'(st.cnt + 8'd1);
                    end else begin
                        next_st.cnt = 8'(st.cnt - 8'd1);
                    end
                end
            end
            default: begin
                // Reserved modes hold the counter and outputs
                next_st.count_up = 1'b1;
            end
        endcase

        // APB slave: answer registered one cycle after setup
        setup  = apb_req.psel && !apb_req.penable;
        access = apb_req.psel && apb_req.penable && st.rsp.pready;
        wr     = access && apb_req.pwrite && !st.rsp.pslverr;
        if (setup) begin
            next_st.rsp.pready  = 1'b1;
            next_st.rsp.pslverr = !mapped(apb_req.paddr);
            next_st.rsp.prdata  = {24'h00_0000, reg_read(st, apb_req.paddr)};
        end else begin
            next_st.rsp.pready  = 1'b0;
            next_st.rsp.pslverr = 1'b0;
        end

        force_a = wr && (apb_req.paddr == `TW_OFF_CTRL_B) && wbyte[`TW_BIT_FORCE_A] && (kind == TW_NONPWM);
        force_b = wr && (apb_req.paddr == `TW_OFF_CTRL_B) && wbyte[`TW_BIT_FORCE_B] && (kind == TW_NONPWM);

        next_st.oc_a = oc_step(st.ctrl_a[7:6], kind, match_a, force_a, wrap, peak, st.count_up,
                               st.act_a == top, st.ctrl_b[`TW_BIT_WAVE_HI], st.oc_a);
        // Channel B field 01 in PWM is reserved and never toggles
        next_st.oc_b = oc_step(st.ctrl_a[5:4], kind, match_b, force_b, wrap, peak, st.count_up,
                               st.act_b == top, 1'b0, st.oc_b);

        if (wr) begin
            case (apb_req.paddr)
                `TW_OFF_CTRL_A:   next_st.ctrl_a = wbyte & `TW_CTRL_A_RMASK;
                `TW_OFF_CTRL_B:   next_st.ctrl_b = wbyte[3:0];
                `TW_OFF_COUNT: begin
                    next_st.cnt   = wbyte;
                    next_st.block = 1'b1;
                end
                `TW_OFF_CMP_A:    next_st.cmp_a = wbyte;
                `TW_OFF_CMP_B:    next_st.cmp_b = wbyte;
                `TW_OFF_IRQ_MASK: next_st.mask = wbyte[2:0];
                `TW_OFF_PORT:     next_st.port = wbyte[3:0];
                default:          next_st.port = st.port;
            endcase
        end

        // Non-PWM and reserved modes see compare values immediately
        next_kind = wave_kind({next_st.ctrl_b[`TW_BIT_WAVE_HI], next_st.ctrl_a[1:0]});
        if (next_kind == TW_NONPWM || next_kind == TW_RSVD) begin
            next_st.act_a = next_st.cmp_a;
            next_st.act_b = next_st.cmp_b;
        end

        // Sticky events; a read clears only what it returned, so a new event wins
        stat_set = 3'b000;
        stat_set[`TW_STAT_OVF]     = ovf;
        stat_set[`TW_STAT_MATCH_A] = match_a;
        stat_set[`TW_STAT_MATCH_B] = match_b;
        if (access && !apb_req.pwrite && apb_req.paddr == `TW_OFF_IRQ_STAT) begin
            next_st.stat = (st.stat & ~st.rsp.prdata[2:0]) | stat_set;
        end else begin
            next_st.stat = st.stat | stat_set;
        end
        next_st.irq = |(next_st.stat & next_st.mask);

        // Pin ownership: compare output when its field is nonzero, else port data
        // PWM field 01 without the high mode bit leaves pin A to the port
        link_a = (next_st.ctrl_a[7:6] == 2'b01) ?
                 (next_kind == TW_NONPWM || next_kind == TW_RSVD || next_st.ctrl_b[`TW_BIT_WAVE_HI]) :
                 (next_st.ctrl_a[7:6] != 2'b00);
        next_st.pin_a.out  = link_a ? next_st.oc_a : next_st.port[2];
        next_st.pin_a.oe_n = ~next_st.port[0];
        next_st.pin_b.out  = (next_st.ctrl_a[5:4] != 2'b00) ? next_st.oc_b : next_st.port[3];
        next_st.pin_b.oe_n = ~next_st.port[1];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st            <= '0;
            st.ctrl_a     <= `TW_CTRL_A_RST;
            st.count_up   <= 1'b1;
            st.pin_a.oe_n <= 1'b1;
            st.pin_b.oe_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign apb_rsp = st.rsp;
    assign pin_a   = st.pin_a;
    assign pin_b   = st.pin_b;
    assign irq     = st.irq;

endmodule

/* File: verif/tw_assertions.sv */
/*
  Concurrent checks on the ports of the timer waveform block.
  Assumes one clock domain and binding onto tw_top.
*/
`timescale 1ns/1ps
`include "tw_cfg.svh"
module tw_assertions
    import tw_pkg::*;
(
    input wire logic                pclk,
    input wire logic                presetn,
    input wire tw_pkg::tw_apb_req_t apb_req,
    input wire tw_pkg::tw_apb_rsp_t apb_rsp,
    input wire tw_pkg::tw_pin_t     pin_a,
    input wire tw_pkg::tw_pin_t     pin_b,
    input wire logic                irq
);
    logic mapped;
    logic rd_ok;
    logic wr_port;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign mapped  = apb_req.paddr inside {`TW_OFF_CTRL_A, `TW_OFF_CTRL_B, `TW_OFF_COUNT, `TW_OFF_CMP_A,
                                           `TW_OFF_CMP_B, `TW_OFF_IRQ_STAT, `TW_OFF_IRQ_MASK, `TW_OFF_PORT};
    assign rd_ok   = apb_rsp.pready && !apb_req.pwrite && !apb_rsp.pslverr;
    assign wr_port = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
                     && apb_req.paddr == `TW_OFF_PORT;

    pready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("pready longer than one cycle");
    setup_answer_a: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
        else $error("no answer after setup");
    err_paired_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready) else $error("pslverr without pready");
    unmapped_err_a: assert property (apb_rsp.pready && !mapped |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (apb_rsp.pready && mapped |-> !apb_rsp.pslverr) else $error("mapped access refused");
    rdata_hold_a: assert property (!(apb_req.psel && !apb_req.penable) |=> $stable(apb_rsp.prdata))
        else $error("read data moved outside setup");
    ctrl_a_rsvd_a: assert property (rd_ok && apb_req.paddr == `TW_OFF_CTRL_A
        |-> (apb_rsp.prdata & 32'hFFFF_FF0C) == 32'h0000_0000) else $error("reserved control bits read nonzero");
    ctrl_b_strobe_a: assert property (rd_ok && apb_req.paddr == `TW_OFF_CTRL_B
        |-> (apb_rsp.prdata & 32'hFFFF_FFF0) == 32'h0000_0000) else $error("force strobes read nonzero");
    drive_cause_a: assert property (!$stable(pin_a.oe_n) || !$stable(pin_b.oe_n)
        |-> $past(wr_port) || $past(wr_port, 2)) else $error("driver enable moved without a port write");

    cover property (apb_rsp.pready && apb_rsp.pslverr);
    cover property ($rose(irq));
    cover property ($rose(pin_a.out) ##[1:600] $fell(pin_a.out));
endmodule

bind tw_top tw_assertions u_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
                                 .pin_a(pin_a), .pin_b(pin_b), .irq(irq));

/* File: verif/tw_load.sv */
/*
  External load on the two compare pins, pulled low while not driven.
  Assumes the pin carriers of tw_top.
*/
`timescale 1ns/1ps
module tw_load
    import tw_pkg::*;
(
    input  wire tw_pkg::tw_pin_t pin_a,
    input  wire tw_pkg::tw_pin_t pin_b,
    output logic                 level_a,
    output logic                 level_b
);
    assign level_a = pin_a.oe_n ? 1'b0 : pin_a.out;
    assign level_b = pin_b.oe_n ? 1'b0 : pin_b.out;
endmodule

/* File: verif/test_tw_top.sv */
/*
  Self-checking bench of the timer waveform block over APB.
  Assumes tw_top, tw_load and the bound checker.
*/
`timescale 1ns/1ps
`include "tw_cfg.svh"
`define TW_CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module test_tw_top;
    import tw_pkg::*;
    typedef struct packed {
        logic [1:0]  mode;
        logic        hi;
        logic [1:0]  com;
        logic [7:0]  cmp;
        logic [11:0] win;
        logic [11:0] high;
    } tw_row_t;
    logic           pclk;
    logic           presetn;
    tw_apb_req_t    apb_req;
    tw_apb_rsp_t    apb_rsp;
    tw_pin_t        pin_a;
    tw_pin_t        pin_b;
    logic           irq;
    logic           lvl_a;
    logic           lvl_b;
    int             n_mismatch = 0;
    int             checks = 0;
    tw_row_t        rows [7] = '{'{2'h3, 1'b0, 2'h2, 8'h80, 12'h200, 12'h102},
                                 '{2'h3, 1'b0, 2'h3, 8'h80, 12'h200, 12'h0FE},
                                 '{2'h3, 1'b0, 2'h2, 8'hFF, 12'h200, 12'h200},
                                 '{2'h3, 1'b0, 2'h1, 8'h80, 12'h200, 12'h000},
                                 '{2'h1, 1'b0, 2'h2, 8'h80, 12'h3FC, 12'h200},
                                 '{2'h1, 1'b0, 2'h2, 8'hFF, 12'h3FC, 12'h3FC},
                                 '{2'h3, 1'b1, 2'h1, 8'h3F, 12'h200, 12'h100}};

    tw_top DUT (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
                .pin_a(pin_a), .pin_b(pin_b), .irq(irq));
    tw_load u_load (.pin_a(pin_a), .pin_b(pin_b), .level_a(lvl_a), .level_b(lvl_b));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h00_0000, d}};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        if (n >= 20) n_mismatch++;
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 8'h00, q, e);
    endtask

    task automatic t_regs;
        logic [31:0] q;
        logic        e;
        rd(`TW_OFF_CTRL_A, q);
        `TW_CHK(q, 32'h0000_0000)
        wr(`TW_OFF_CTRL_A, 8'hFF);
        rd(`TW_OFF_CTRL_A, q);
        `TW_CHK(q, 32'h0000_00F3)
        wr(`TW_OFF_CTRL_B, 8'hF8);
        rd(`TW_OFF_CTRL_B, q);
        `TW_CHK(q, 32'h0000_0008)
        apb(1'b0, 8'h10, 8'h00, q, e);
        `TW_CHK(e, 1'b1)
        wr(`TW_OFF_CTRL_A, 8'h00);
        wr(`TW_OFF_CTRL_B, 8'h00);
        $display("register test done");
    endtask

    task automatic t_force;
        logic [31:0] q;
        logic [3:0]  expect_lvl;
        expect_lvl = 4'b1010;
        wr(`TW_OFF_PORT, 8'h03);
        for (int i = 1; i < 4; i++) begin
            wr(`TW_OFF_CTRL_A, {i[1:0], i[1:0], 4'h0});
            wr(`TW_OFF_CTRL_B, 8'hC0);
            repeat (3) @(posedge pclk);
            `TW_CHK(lvl_a, expect_lvl[i])
            `TW_CHK(lvl_b, expect_lvl[i])
        end
        rd(`TW_OFF_IRQ_STAT, q);
        `TW_CHK(q, 32'h0000_0000)
        wr(`TW_OFF_CTRL_A, 8'h00);
        wr(`TW_OFF_PORT, 8'h0F);
        repeat (3) @(posedge pclk);
        `TW_CHK({lvl_a, lvl_b}, 2'b11)
        wr(`TW_OFF_PORT, 8'h03);
        $display("force test done");
    endtask

    task automatic t_irq;
        logic [31:0] q;
        wr(`TW_OFF_CTRL_A, 8'h40);
        wr(`TW_OFF_CMP_A, 8'h10);
        wr(`TW_OFF_IRQ_MASK, 8'h00);
        wr(`TW_OFF_CTRL_B, 8'h01);
        repeat (300) @(posedge pclk);
        wr(`TW_OFF_CTRL_B, 8'h00);
        `TW_CHK(irq, 1'b0)
        wr(`TW_OFF_IRQ_MASK, 8'h02);
        repeat (3) @(posedge pclk);
        `TW_CHK(irq, 1'b1)
        rd(`TW_OFF_IRQ_STAT, q);
        `TW_CHK(q, 32'h0000_0007)
        repeat (3) @(posedge pclk);
        `TW_CHK(irq, 1'b0)
        $display("interrupt test done");
    endtask

    task automatic t_pwm;
        logic [11:0] ha;
        logic [11:0] hb;
        foreach (rows[i]) begin
            wr(`TW_OFF_CTRL_B, 8'h00);
            wr(`TW_OFF_CMP_A, rows[i].cmp);
            wr(`TW_OFF_CMP_B, rows[i].cmp);
            wr(`TW_OFF_CTRL_A, {rows[i].com, rows[i].com, 2'b00, rows[i].mode});
            wr(`TW_OFF_CTRL_B, {4'h0, rows[i].hi, 3'b001});
            repeat (600) @(posedge pclk);
            ha = 12'h000;
            hb = 12'h000;
            repeat (rows[i].win) begin
                @(posedge pclk);
                if (lvl_a === 1'b1) ha++;
                if (lvl_b === 1'b1) hb++;
            end
            `TW_CHK(ha, rows[i].high)
            if (rows[i].com != 2'h1) `TW_CHK(hb, rows[i].high)
            else `TW_CHK(hb == 12'h000 || hb == rows[i].win, 1'b1)
        end
        wr(`TW_OFF_CTRL_B, 8'h00);
        $display("waveform test done");
    endtask

    task automatic t_ctc;
        logic [31:0] q;
        logic [11:0] ha;
        wr(`TW_OFF_CTRL_B, 8'h00);
        wr(`TW_OFF_CMP_A, 8'h0F);
        wr(`TW_OFF_CTRL_A, 8'h42);
        wr(`TW_OFF_COUNT, 8'h00);
        rd(`TW_OFF_IRQ_STAT, q);
        wr(`TW_OFF_CTRL_B, 8'h02);
        ha = 12'h000;
        repeat (1024) begin
            @(posedge pclk);
            if (lvl_a === 1'b1) ha++;
        end
        `TW_CHK(ha, 12'h200)
        rd(`TW_OFF_COUNT, q);
        `TW_CHK(q[31:4], 28'h000_0000)
        rd(`TW_OFF_CMP_A, q);
        `TW_CHK(q, 32'h0000_000F)
        wr(`TW_OFF_CTRL_B, 8'h00);
        rd(`TW_OFF_IRQ_STAT, q);
        `TW_CHK(q, 32'h0000_0002)
        $display("clear-on-match test done");
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        presetn = 1'b0;
        apb_req = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_force();
        t_irq();
        t_pwm();
        t_ctc();
        report_and_stop();
    end

    initial begin
        repeat (40000) @(posedge pclk);
        n_mismatch++;
        report_and_stop();
    end
endmodule
